// ===== burst_lane_map.vh
// Purpose: register offsets, field positions and reset values of the burst and lane block
// Assumes: byte registers, one per aligned 32-bit AHB word
// Notes:   offsets 0x17 and 0x19..0x21 are register indices; byte address = index * 4
// Operation
// - the fine-sample marker placement only takes effect while 14-bit burst mode is on, one sample per 16-bit word.
// - the two-bit placement field means 00 noise bits (the code drives both bits zero), 01 marker on bit 0, 10 marker on bit 1, 11 marker on both bits.
// - an enabled marker bit is one for a fine-resolution sample and zero for a coarse one.
// - the trigger pin choice bit selects the first pair trigger pin when clear and the second when set.
// - with self trigger enabled the burst is triggered internally and both trigger pins are ignored.
// - a status alarm bit is raised whenever the fine to coarse count ratio is invalid.
// - the 28-bit coarse period count is built from four byte registers, the top one holding bits 27..24 in its low nibble.
// - the 28-bit fine period count is built from four byte registers, the top one holding bits 27..24 in its low nibble.
// - channel A goes to lane A for code 00 and to lane B for code 10; 01 and 11 are not used.
// - channel B goes to lane B for code 00 and to lane A for code 10; 01 and 11 are not used.
// - channel C goes to lane C for code 00 and to lane D for code 10; 01 and 11 are not used.
// - channel D goes to lane D for code 00 and to lane C for code 10; 01 and 11 are not used.
`ifndef BURST_LANE_MAP_VH
`define BURST_LANE_MAP_VH

// ****************************************************************
// register indices
// ****************************************************************
`define REG_BURST_CTRL     8'h17
`define REG_LOW_B3         8'h19
`define REG_LOW_B2         8'h1A
`define REG_LOW_B1         8'h1B
`define REG_LOW_B0         8'h1C
`define REG_HIGH_B3        8'h1D
`define REG_HIGH_B2        8'h1E
`define REG_HIGH_B1        8'h1F
`define REG_HIGH_B0        8'h20
`define REG_LANE_ROUTE     8'h21
`define REG_IRQ_STATUS     8'h30
`define REG_IRQ_MASK       8'h31
`define REG_MODE           8'h32

// ****************************************************************
// fields
// ****************************************************************
`define CTRL_MARK_HI       7
`define CTRL_MARK_LO       6
`define CTRL_TRIG_CHOICE   4
`define CTRL_SELF_TRIG     3
`define CTRL_RATIO_BAD     1
`define CTRL_WR_MASK       8'hD8
`define IRQ_RATIO_BAD      0
`define IRQ_TRIGGER        1
`define IRQ_BITS           2
`define ROUTE_STRAIGHT     2'h0
`define ROUTE_SWAP         2'h2
`define RESET_BYTE         8'h00

`endif

// ===== burst_lane_select.v
// Purpose: burst-mode sample marking, trigger choice, period counters and lane routing
// Assumes: AHB-Lite slave with one-cycle address phase, zero-wait data phase, always OKAY
// Notes:   samples are 14 bits, left-aligned in 16-bit lane words
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "burst_lane_map.vh"

module burst_lane_select #(
	parameter SAMPLE_W = 14,
	parameter COUNT_W  = 28
) (
	// clock and reset
	input  wire                clk_i,
	input  wire                srst_i,
	// ahb-lite slave
	input  wire                hsel_i,
	input  wire [31:0]         haddr_i,
	input  wire [1:0]          htrans_i,
	input  wire                hwrite_i,
	input  wire [2:0]          hsize_i,
	input  wire [31:0]         hwdata_i,
	input  wire                hready_i,
	output reg  [31:0]         hrdata_o,
	output reg                 hreadyout_o,
	output reg                 hresp_o,
	// trigger pins
	input  wire                first_pair_trigger_pin_i,
	input  wire                second_pair_trigger_pin_i,
	// channel samples, fine and coarse resolution
	input  wire [SAMPLE_W-1:0] chan_a_i,
	input  wire [SAMPLE_W-1:0] chan_b_i,
	input  wire [SAMPLE_W-1:0] chan_c_i,
	input  wire [SAMPLE_W-1:0] chan_d_i,
	// serial lane words
	output reg  [15:0]         lane_a_o,
	output reg  [15:0]         lane_b_o,
	output reg  [15:0]         lane_c_o,
	output reg  [15:0]         lane_d_o,
	// status
	output reg                 fine_phase_o,
	output reg                 irq_o
);

	// ****************************************************************
	// register state
	// ****************************************************************
	reg  [7:0]         ctrl;
	reg  [7:0]         low_b [0:3];
	reg  [7:0]         high_b [0:3];
	reg  [7:0]         lane_route;
	reg  [COUNT_W-1:0] coarse_period_count;
	reg  [COUNT_W-1:0] fine_period_count;
	reg  [`IRQ_BITS-1:0] irq_status;
	reg  [`IRQ_BITS-1:0] irq_mask;
	reg                burst_mode;
	reg                wr_pend;
	reg  [7:0]         wr_idx;

	// burst sequencer
	localparam ST_IDLE   = 2'h0;
	localparam ST_FINE   = 2'h1;
	localparam ST_COARSE = 2'h2;
	reg  [1:0]         state;
	reg  [COUNT_W-1:0] phase_cnt;
	reg                trig_q;

	wire [1:0] fine_sample_marker_place = ctrl[`CTRL_MARK_HI:`CTRL_MARK_LO];
	wire       trigger_pin_choice       = ctrl[`CTRL_TRIG_CHOICE];
	wire       self_trigger_enable      = ctrl[`CTRL_SELF_TRIG];
	wire [1:0] chan_a_lane_route        = lane_route[7:6];
	wire [1:0] chan_b_lane_route        = lane_route[5:4];
	wire [1:0] chan_c_lane_route        = lane_route[3:2];
	wire [1:0] chan_d_lane_route        = lane_route[1:0];

	// ****************************************************************
	// bus decode
	// ****************************************************************
	wire       addr_ok  = hsel_i && hready_i && htrans_i[1];
	wire [7:0] addr_idx = haddr_i[9:2];
	wire       wr_now   = wr_pend;
	wire [7:0] wdata    = hwdata_i[7:0];

	// both counts must be nonzero; a zero count would wrap and stretch one phase to 2^28 cycles
	wire ratio_bad = (coarse_period_count == {COUNT_W{1'b0}}) ||
	                 (fine_period_count == {COUNT_W{1'b0}});

	// ****************************************************************
	// trigger selection
	// ****************************************************************
	wire pin_trig = trigger_pin_choice ? second_pair_trigger_pin_i : first_pair_trigger_pin_i;
	wire trig_level = pin_trig;
	// self trigger fires whenever the sequencer is idle in burst mode with a valid ratio and ignores both pins;
	// an edge detector alone would miss it when the enable was set before burst mode
	wire trig_rise  = self_trigger_enable ? 1'b1 : (trig_level && !trig_q);
	wire trig_evt   = burst_mode && !ratio_bad && (state == ST_IDLE) && trig_rise;

	function [7:0] read_reg;
		input [7:0] idx;
		begin
			case (idx)
				`REG_BURST_CTRL:  read_reg = (ctrl & `CTRL_WR_MASK) | {6'h00, ratio_bad, 1'b0};
				`REG_LOW_B3:      read_reg = {4'h0, low_b[3][3:0]};
				`REG_LOW_B2:      read_reg = low_b[2];
				`REG_LOW_B1:      read_reg = low_b[1];
				`REG_LOW_B0:      read_reg = low_b[0];
				`REG_HIGH_B3:     read_reg = {4'h0, high_b[3][3:0]};
				`REG_HIGH_B2:     read_reg = high_b[2];
				`REG_HIGH_B1:     read_reg = high_b[1];
				`REG_HIGH_B0:     read_reg = high_b[0];
				`REG_LANE_ROUTE:  read_reg = lane_route;
				`REG_IRQ_STATUS:  read_reg = {6'h00, irq_status};
				`REG_IRQ_MASK:    read_reg = {6'h00, irq_mask};
				`REG_MODE:        read_reg = {state, 5'h00, burst_mode};
				default:          read_reg = 8'h00;
			endcase
		end
	endfunction

	// marks the two spare lsbs of a 16-bit word
	function [15:0] pack_word;
		input [SAMPLE_W-1:0] smp;
		input                fine;
		input                bmode;
		input [1:0]          place;
		reg   [1:0]          lsb;
		begin
			lsb = 2'h0;
			if (bmode) begin
				lsb[0] = place[0] & fine;
				lsb[1] = place[1] & fine;
			end
			pack_word = {smp, lsb};
		end
	endfunction

	// code 10 swaps the pair; unused codes fall back to straight routing
	function [SAMPLE_W-1:0] route_pick;
		input [1:0]          code;
		input [SAMPLE_W-1:0] own;
		input [SAMPLE_W-1:0] partner;
		begin
			route_pick = (code == `ROUTE_SWAP) ? partner : own;
		end
	endfunction

	// ****************************************************************
	// registers and bus
	// ****************************************************************
	integer i;
	always @(posedge clk_i) begin
		if (srst_i) begin
			ctrl        <= `RESET_BYTE;
			lane_route  <= `RESET_BYTE;
			for (i = 0; i < 4; i = i + 1) begin
				low_b[i]  <= `RESET_BYTE;
				high_b[i] <= `RESET_BYTE;
			end
			coarse_period_count <= {COUNT_W{1'b0}};
			fine_period_count   <= {COUNT_W{1'b0}};
			irq_mask    <= {`IRQ_BITS{1'b0}};
			irq_status  <= {`IRQ_BITS{1'b0}};
			burst_mode  <= 1'b0;
			wr_pend     <= 1'b0;
			wr_idx      <= 8'h00;
			hrdata_o    <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			irq_o       <= 1'b0;
		end else begin
			wr_pend <= addr_ok && hwrite_i;
			if (addr_ok)
				wr_idx <= addr_idx;
			if (addr_ok && !hwrite_i)
				hrdata_o <= {24'h000000, read_reg(addr_idx)};
			if (wr_now) begin
				case (wr_idx)
					`REG_BURST_CTRL: ctrl <= wdata & `CTRL_WR_MASK;
					`REG_LOW_B0:     low_b[0] <= wdata;
					`REG_LOW_B1:     low_b[1] <= wdata;
					`REG_LOW_B2:     low_b[2] <= wdata;
					`REG_LOW_B3: begin
						low_b[3] <= {4'h0, wdata[3:0]};
						// top byte commits the whole count
						coarse_period_count <= {wdata[3:0], low_b[2], low_b[1], low_b[0]};
					end
					`REG_HIGH_B0:    high_b[0] <= wdata;
					`REG_HIGH_B1:    high_b[1] <= wdata;
					`REG_HIGH_B2:    high_b[2] <= wdata;
					`REG_HIGH_B3: begin
						high_b[3] <= {4'h0, wdata[3:0]};
						fine_period_count <= {wdata[3:0], high_b[2], high_b[1], high_b[0]};
					end
					`REG_LANE_ROUTE: lane_route <= wdata;
					`REG_IRQ_MASK:   irq_mask <= wdata[`IRQ_BITS-1:0];
					`REG_MODE:       burst_mode <= wdata[0];
					default:         ;
				endcase
			end
			// set wins over write-one-to-clear
			irq_status[`IRQ_RATIO_BAD] <= (ratio_bad && burst_mode) ||
				(irq_status[`IRQ_RATIO_BAD] &&
				 !(wr_now && wr_idx == `REG_IRQ_STATUS && wdata[`IRQ_RATIO_BAD]));
			irq_status[`IRQ_TRIGGER] <= trig_evt ||
				(irq_status[`IRQ_TRIGGER] &&
				 !(wr_now && wr_idx == `REG_IRQ_STATUS && wdata[`IRQ_TRIGGER]));
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// ****************************************************************
	// burst sequencer
	// ****************************************************************
	always @(posedge clk_i) begin
		if (srst_i) begin
			state        <= ST_IDLE;
			phase_cnt    <= {COUNT_W{1'b0}};
			trig_q       <= 1'b0;
			fine_phase_o <= 1'b0;
		end else begin
			trig_q <= trig_level;
			case (state)
				ST_IDLE: begin
					if (trig_evt) begin
						state     <= ST_FINE;
						phase_cnt <= fine_period_count;
					end
				end
				ST_FINE: begin
					if (phase_cnt == {{(COUNT_W-1){1'b0}}, 1'b1}) begin
						state     <= ST_COARSE;
						phase_cnt <= coarse_period_count;
					end else
						phase_cnt <= phase_cnt - 1'b1;
				end
				ST_COARSE: begin
					if (phase_cnt == {{(COUNT_W-1){1'b0}}, 1'b1}) begin
						state     <= ST_FINE;
						phase_cnt <= fine_period_count;
					end else
						phase_cnt <= phase_cnt - 1'b1;
				end
				default: state <= ST_IDLE;
			endcase
			// leaving burst mode or a bad ratio stops the cycle
			if (!burst_mode || ratio_bad)
				state <= ST_IDLE;
			fine_phase_o <= (state == ST_FINE);
		end
	end

	// ****************************************************************
	// lane routing
	// ****************************************************************
	// outside burst mode every sample counts as full resolution
	wire fine_now = !burst_mode || (state == ST_FINE);

	always @(posedge clk_i) begin
		if (srst_i) begin
			lane_a_o <= 16'h0000;
			lane_b_o <= 16'h0000;
			lane_c_o <= 16'h0000;
			lane_d_o <= 16'h0000;
		end else begin
			// lane a carries b when b is swapped; the pair codes are assumed consistent
			lane_a_o <= pack_word(route_pick(chan_b_lane_route, chan_a_i, chan_b_i),
			                      fine_now, burst_mode, fine_sample_marker_place);
			lane_b_o <= pack_word(route_pick(chan_a_lane_route, chan_b_i, chan_a_i),
			                      fine_now, burst_mode, fine_sample_marker_place);
			lane_c_o <= pack_word(route_pick(chan_d_lane_route, chan_c_i, chan_d_i),
			                      fine_now, burst_mode, fine_sample_marker_place);
			lane_d_o <= pack_word(route_pick(chan_c_lane_route, chan_d_i, chan_c_i),
			                      fine_now, burst_mode, fine_sample_marker_place);
		end
	end

endmodule

// ===== link_rx_model.sv
// Purpose: receiver-side model that latches the four lane words
// Assumes: one word per lane per sample clock
// Notes:   counts words marked fine on lane a bit 0
`timescale 1ns/1ps
module link_rx_model (
	input  wire        clk_i,
	input  wire        clr_i,
	input  wire [15:0] lane_a_i,
	input  wire [15:0] lane_b_i,
	input  wire [15:0] lane_c_i,
	input  wire [15:0] lane_d_i,
	output reg  [63:0] word_o,
	output reg  [15:0] fine_cnt_o
);
	always @(posedge clk_i) begin
		word_o <= {lane_a_i, lane_b_i, lane_c_i, lane_d_i};
		if (clr_i)
			fine_cnt_o <= 16'h0000;
		else
			fine_cnt_o <= fine_cnt_o + {15'h0000, lane_a_i[0]};
	end
endmodule

// ===== burst_lane_props.sv
// Purpose: port checks of burst_lane_select
// Assumes: zero-wait bus, register index in haddr[9:2]
// Notes:   marker field and burst enable shadowed from bus writes
`timescale 1ns/1ps
`include "burst_lane_map.vh"
module burst_lane_props #(
	parameter SAMPLE_W = 14
) (
	input wire                clk_i,
	input wire                srst_i,
	input wire                hsel_i,
	input wire [31:0]         haddr_i,
	input wire [1:0]          htrans_i,
	input wire                hwrite_i,
	input wire [31:0]         hwdata_i,
	input wire [SAMPLE_W-1:0] chan_a_i,
	input wire [SAMPLE_W-1:0] chan_b_i,
	input wire [SAMPLE_W-1:0] chan_c_i,
	input wire [SAMPLE_W-1:0] chan_d_i,
	input wire [15:0]         lane_a_o,
	input wire [15:0]         lane_b_o,
	input wire [15:0]         lane_c_o,
	input wire [15:0]         lane_d_o,
	input wire                fine_phase_o
);
	reg       ap;
	reg [7:0] ai;
	reg [1:0] mk;
	reg       bm;
	always @(posedge clk_i) begin
		ai <= haddr_i[9:2];
		if (srst_i) begin
			ap <= 1'b0;
			mk <= 2'h0;
			bm <= 1'b0;
		end else begin
			ap <= hsel_i & htrans_i[1] & hwrite_i;
			if (ap && ai == `REG_BURST_CTRL)
				mk <= hwdata_i[7:6];
			if (ap && ai == `REG_MODE)
				bm <= hwdata_i[0];
		end
	end
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (srst_i);
	lane_a_src_a: assert property (!$past(srst_i) |->
		lane_a_o[15:2] == $past(chan_a_i) || lane_a_o[15:2] == $past(chan_b_i)) else $error("lane a source");
	lane_b_src_a: assert property (!$past(srst_i) |->
		lane_b_o[15:2] == $past(chan_b_i) || lane_b_o[15:2] == $past(chan_a_i)) else $error("lane b source");
	lane_c_src_a: assert property (!$past(srst_i) |->
		lane_c_o[15:2] == $past(chan_c_i) || lane_c_o[15:2] == $past(chan_d_i)) else $error("lane c source");
	lane_d_src_a: assert property (!$past(srst_i) |->
		lane_d_o[15:2] == $past(chan_d_i) || lane_d_o[15:2] == $past(chan_c_i)) else $error("lane d source");
	mark_bit0_a: assert property (!$past(srst_i) && $past(bm) && $past(mk[0]) |->
		lane_a_o[0] == fine_phase_o) else $error("bit 0 marker wrong");
	mark_bit1_a: assert property (!$past(srst_i) && $past(bm) && $past(mk[1]) |->
		lane_c_o[1] == fine_phase_o) else $error("bit 1 marker wrong");
	mark_off_a: assert property (!$past(srst_i) && !$past(bm) |->
		lane_b_o[1:0] == 2'h0) else $error("marker outside burst");
	burst_gate_a: assert property ($rose(fine_phase_o) |-> $past(bm))
		else $error("fine phase without burst mode");
endmodule
bind burst_lane_select burst_lane_props #(.SAMPLE_W(SAMPLE_W)) props_inst (
	.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .chan_a_i(chan_a_i), .chan_b_i(chan_b_i),
	.chan_c_i(chan_c_i), .chan_d_i(chan_d_i), .lane_a_o(lane_a_o), .lane_b_o(lane_b_o),
	.lane_c_o(lane_c_o), .lane_d_o(lane_d_o), .fine_phase_o(fine_phase_o)
);

// ===== tb_burst_lane_select.sv
// Purpose: self-checking bench for burst_lane_select
// Assumes: zero-wait bus, registers at index * 4
// Notes:   counts kept tiny so whole burst phases are measured
`timescale 1ns/1ps
`include "burst_lane_map.vh"
module tb_burst_lane_select;
	reg         clk_i = 1'b0;
	reg         srst_i = 1'b1;
	reg         hsel_i = 1'b0;
	reg         hwrite_i = 1'b0;
	reg  [1:0]  htrans_i = 2'h0;
	reg  [31:0] haddr_i = 32'h0;
	reg  [31:0] hwdata_i = 32'h0;
	reg         tp1 = 1'b0;
	reg         tp2 = 1'b0;
	reg         clr = 1'b1;
	reg  [13:0] ca = 14'h1111;
	reg  [13:0] cb = 14'h2222;
	reg  [13:0] cc = 14'h3333;
	reg  [13:0] cd = 14'h0444;
	reg  [31:0] rd;
	wire [31:0] hrdata_o;
	wire        hreadyout_o;
	wire        fine_phase_o;
	wire        irq_o;
	wire        hresp;
	wire [15:0] la, lb, lc, ld, fine_cnt;
	wire [63:0] words;
	integer     error_cnt = 0;
	integer     cmp_count = 0;
	integer     cyc = 0;
	integer     i;
	integer     n;
	burst_lane_select burst_lane_select_inst (
		.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp),
		.first_pair_trigger_pin_i(tp1), .second_pair_trigger_pin_i(tp2),
		.chan_a_i(ca), .chan_b_i(cb), .chan_c_i(cc), .chan_d_i(cd), .lane_a_o(la),
		.lane_b_o(lb), .lane_c_o(lc), .lane_d_o(ld), .fine_phase_o(fine_phase_o), .irq_o(irq_o));
	link_rx_model link_rx_model_inst (.clk_i(clk_i), .clr_i(clr), .lane_a_i(la), .lane_b_i(lb),
		.lane_c_i(lc), .lane_d_i(ld), .word_o(words), .fine_cnt_o(fine_cnt));
	initial forever #4 clk_i = ~clk_i;
	// ****************************************************************
	// helpers
	// ****************************************************************
	task report_and_stop;
	begin
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input [63:0] got, input [63:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task bus(input w, input [7:0] idx, input [31:0] wd);
	begin
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {22'h0, idx, 2'h0};
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		rd = hrdata_o;
	end
	endtask
	task pulse(input sel);
	begin
		tp1 <= !sel;
		tp2 <= sel;
		@(posedge clk_i);
		tp1 <= 1'b0;
		tp2 <= 1'b0;
	end
	endtask
	// bounded: gives up after 40 samples of the same level
	task span(input v);
	begin
		n = 0;
		while (fine_phase_o === v && n < 40) begin
			@(posedge clk_i);
			n = n + 1;
		end
	end
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt = error_cnt + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 8'h19; i <= 8'h21; i = i + 1) begin
			bus(1'b0, i[7:0], 32'h0);
			chk(rd, 32'h0);
		end
		bus(1'b1, `REG_BURST_CTRL, 32'hFF);
		bus(1'b0, `REG_BURST_CTRL, 32'h0);
		chk(rd & 32'hFD, 32'hD8);
		bus(1'b1, 8'h40, 32'hFF);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		chk(hresp, 1'b0);
		bus(1'b1, `REG_BURST_CTRL, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			bus(1'b1, `REG_LANE_ROUTE, {24'h0, i[0] ? 4'hA : 4'h0, i[1] ? 4'hA : 4'h0});
			repeat (3) @(posedge clk_i);
			chk(words[63:34], {i[0] ? cb : ca, 2'h0, i[0] ? ca : cb});
			chk(words[31:2], {i[1] ? cd : cc, 2'h0, i[1] ? cc : cd});
		end
		bus(1'b1, `REG_MODE, 32'h1);
		bus(1'b1, `REG_LOW_B0, 32'h3);
		bus(1'b1, `REG_LOW_B1, 32'h0);
		bus(1'b1, `REG_LOW_B2, 32'h0);
		bus(1'b1, `REG_LOW_B3, 32'hF0);
		bus(1'b1, `REG_HIGH_B0, 32'h4);
		bus(1'b1, `REG_HIGH_B1, 32'h0);
		bus(1'b1, `REG_HIGH_B2, 32'h0);
		repeat (2) @(posedge clk_i);
		bus(1'b0, `REG_BURST_CTRL, 32'h0);
		chk(rd[1], 1'b1);
		bus(1'b1, `REG_HIGH_B3, 32'h0);
		repeat (2) @(posedge clk_i);
		bus(1'b0, `REG_BURST_CTRL, 32'h0);
		chk(rd[1], 1'b0);
		bus(1'b0, `REG_LOW_B3, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `REG_IRQ_STATUS, 32'h0);
		chk(rd[0], 1'b1);
		bus(1'b1, `REG_IRQ_STATUS, 32'h3);
		bus(1'b1, `REG_IRQ_MASK, 32'h2);
		bus(1'b1, `REG_BURST_CTRL, 32'h40);
		clr <= 1'b0;
		pulse(1'b1);
		span(1'b0);
		chk(n, 32'h28);
		pulse(1'b0);
		span(1'b0);
		span(1'b1);
		chk(n, 32'h4);
		span(1'b0);
		chk(n, 32'h3);
		chk(fine_cnt, 16'h4);
		chk(irq_o, 1'b1);
		bus(1'b1, `REG_IRQ_STATUS, 32'h2);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		bus(1'b1, `REG_MODE, 32'h0);
		bus(1'b1, `REG_BURST_CTRL, 32'h58);
		bus(1'b1, `REG_MODE, 32'h1);
		span(1'b0);
		chk(fine_phase_o, 1'b1);
		for (i = 1; i < 4; i = i + 1) begin
			bus(1'b1, `REG_BURST_CTRL, {24'h0, i[1:0], 6'h08});
			@(posedge clk_i);
			span(1'b1);
			span(1'b0);
			chk(la[1:0], i[1:0]);
			span(1'b1);
			chk(lb[1:0], 2'h0);
		end
		report_and_stop;
	end
endmodule
